// File: oper_pkg.sv
// oper_pkg: register map, field positions and reset values of the
// detector event logic.
// assumes: 6-bit register addresses, 8-bit register data.
package oper_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [5:0] OPER_ADDR_RISE_WR  = 6'h0D;
	localparam logic [5:0] OPER_ADDR_RISE_SET = 6'h0E;
	localparam logic [5:0] OPER_ADDR_RISE_CLR = 6'h0F;
	localparam logic [5:0] OPER_ADDR_FALL_WR  = 6'h10;
	localparam logic [5:0] OPER_ADDR_FALL_SET = 6'h11;
	localparam logic [5:0] OPER_ADDR_FALL_CLR = 6'h12;
	localparam logic [5:0] OPER_ADDR_STATUS   = 6'h13;
	localparam logic [5:0] OPER_ADDR_LATCH    = 6'h14;
	// ------------------------------------------------------------
	// field positions, common to status, enables and latch
	// ------------------------------------------------------------
	localparam int OPER_BIT_ID_GROUND      = 4;
	localparam int OPER_BIT_SESSION_END    = 3;
	localparam int OPER_BIT_SESSION_VALID  = 2;
	localparam int OPER_BIT_BUS_POWER_GOOD = 1;
	localparam int OPER_BIT_DOWNSTREAM_DET = 0;
	localparam int OPER_NSRC               = 5;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OPER_ENABLE_RESET = 8'h1F;
	localparam logic [7:0] OPER_LATCH_RESET  = 8'h00;
	// register operation kind decoded from the address
	typedef enum logic [1:0] {
		OPER_OP_WRITE = 2'b00,
		OPER_OP_SET   = 2'b01,
		OPER_OP_CLEAR = 2'b10,
		OPER_OP_NONE  = 2'b11
	} oper_op_t;
endpackage : oper_pkg

// File: oper_edge_detect.sv
// oper_edge_detect: per-source rising and falling edge detection
// assumes: detector levels already synchronous to MCLK.
`timescale 1ns/1ps
module oper_edge_detect
	import oper_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [OPER_NSRC-1:0]  level,
	output logic      [OPER_NSRC-1:0]  rise,
	output logic      [OPER_NSRC-1:0]  fall
);
	logic [OPER_NSRC-1:0] level_q;

	// previous level; reset to 0 to match the status reset value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= '0;
		end else begin
			level_q <= level;
		end
	end

	assign rise = level & ~level_q;
	assign fall = ~level & level_q;
endmodule : oper_edge_detect

// File: oper_event_logic.sv
// oper_event_logic: detector status, edge enables, event latch and
// event request toward the link.
// assumes: detector inputs synchronous to MCLK; register port is a
// single-cycle strobe interface from the link-side register engine.
//
// Operation
// - rising detector edge with rising enable set raises event and RXCMD
// - falling detector edge with falling enable set raises event and RXCMD
// - both enable registers reset to 1Fh, reserved bits zero
// - rising enable read at 0Dh-0Fh; write 0Dh, set 0Eh, clear 0Fh
// - falling enable read at 10h-12h; write 10h, set 11h, clear 12h
// - status at 13h reads live unlatched detector levels
// - bit 4 id ground, 3 session end, 2 valid, 1 bus power, 0 detach
// - latch bit sets on each unmasked change of its source
// - latch at 14h is read only, resets zero, cleared by read
// - latch cleared on entry to low-power mode; an event in that cycle survives
// - latch bit 4 is id ground; bits 7 to 5 read zero
`timescale 1ns/1ps
module oper_event_logic
	import oper_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	// detector levels
	input  wire logic        ID_GROUND_LEVEL,
	input  wire logic        SESSION_END_LEVEL,
	input  wire logic        SESSION_VALID_LEVEL,
	input  wire logic        BUS_POWER_GOOD_LEVEL,
	input  wire logic        DOWNSTREAM_DETACH_LEVEL,
	// low-power entry, one-cycle pulse
	input  wire logic        LOW_POWER_ENTRY,
	// register port
	input  wire logic [5:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	output logic             REG_HIT,
	// event toward the RXCMD sender
	output logic             EVENT_REQ,
	output logic      [7:0]  EVENT_STATUS,
	output logic             INTR
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [OPER_NSRC-1:0] level;
	logic [OPER_NSRC-1:0] rise;
	logic [OPER_NSRC-1:0] fall;
	logic [OPER_NSRC-1:0] events;
	logic [7:0]           rise_edge_event_enable;
	logic [7:0]           fall_edge_event_enable;
	logic [7:0]           detector_event_latch;
	logic [7:0]           detector_live_status;
	logic [7:0]           next_rise;
	logic [7:0]           next_fall;
	logic [7:0]           next_rdata;
	logic                 next_hit;
	logic                 latch_read;
	logic [OPER_NSRC-1:0] rise_mask;
	logic [OPER_NSRC-1:0] fall_mask;
	logic [OPER_NSRC-1:0] latch_view;
	oper_op_t             rise_op;
	oper_op_t             fall_op;
	// per-field views of the registers and detector inputs
	logic                 id_ground_rise_enable;
	logic                 session_end_rise_enable;
	logic                 session_valid_rise_enable;
	logic                 bus_power_good_rise_enable;
	logic                 downstream_detach_rise_enable;
	logic                 id_ground_fall_enable;
	logic                 session_end_fall_enable;
	logic                 session_valid_fall_enable;
	logic                 bus_power_good_fall_enable;
	logic                 downstream_detach_fall_enable;
	logic                 id_ground_event_latched;
	logic                 session_end_event_latched;
	logic                 session_valid_event_latched;
	logic                 bus_power_good_event_latched;
	logic                 downstream_detach_event_latched;
	logic                 session_valid_signal;
	logic                 bus_power_good_signal;

	// map an address onto a write, set or clear of one register
	function automatic oper_op_t op_of(input logic [5:0] a,
	                                   input logic [5:0] base);
		if (a == base) begin
			return OPER_OP_WRITE;
		end else if (a == base + 6'h01) begin
			return OPER_OP_SET;
		end else if (a == base + 6'h02) begin
			return OPER_OP_CLEAR;
		end
		return OPER_OP_NONE;
	endfunction : op_of

	// apply write, set or clear; upper bits kept zero as reserved
	function automatic logic [7:0] apply_op(input oper_op_t op,
	                                        input logic [7:0] cur,
	                                        input logic [7:0] d);
		logic [7:0] r;
		r = cur;
		case (op)
			OPER_OP_WRITE: r = d;
			OPER_OP_SET:   r = cur | d;
			OPER_OP_CLEAR: r = cur & ~d;
			default:       r = cur;
		endcase
		return r & OPER_ENABLE_RESET;
	endfunction : apply_op

	// place per-source bits at their common field positions
	function automatic logic [OPER_NSRC-1:0] pack_src(input logic ig,
	                                                  input logic se,
	                                                  input logic sv,
	                                                  input logic bp,
	                                                  input logic dd);
		logic [OPER_NSRC-1:0] v;
		v                          = '0;
		v[OPER_BIT_ID_GROUND]      = ig;
		v[OPER_BIT_SESSION_END]    = se;
		v[OPER_BIT_SESSION_VALID]  = sv;
		v[OPER_BIT_BUS_POWER_GOOD] = bp;
		v[OPER_BIT_DOWNSTREAM_DET] = dd;
		return v;
	endfunction : pack_src

	// ------------------------------------------------------------
	// live status
	// ------------------------------------------------------------
	// comparator outputs as this block sees them
	assign session_valid_signal  = SESSION_VALID_LEVEL;
	assign bus_power_good_signal = BUS_POWER_GOOD_LEVEL;

	always_comb begin
		level = '0;
		level[OPER_BIT_ID_GROUND]      = ID_GROUND_LEVEL;
		level[OPER_BIT_SESSION_END]    = SESSION_END_LEVEL;
		level[OPER_BIT_SESSION_VALID]  = session_valid_signal;
		level[OPER_BIT_BUS_POWER_GOOD] = bus_power_good_signal;
		level[OPER_BIT_DOWNSTREAM_DET] = DOWNSTREAM_DETACH_LEVEL;
	end

	// unlatched: status read sees the inputs of this very cycle
	assign detector_live_status = {3'h0, level};

	oper_edge_detect u_edge (
		.clk   (MCLK),
		.rst_n (RSTN),
		.level (level),
		.rise  (rise),
		.fall  (fall)
	);

	// ------------------------------------------------------------
	// field views
	// ------------------------------------------------------------
	// named bits keep the field positions in one place
	assign id_ground_rise_enable =
		rise_edge_event_enable[OPER_BIT_ID_GROUND];
	assign session_end_rise_enable =
		rise_edge_event_enable[OPER_BIT_SESSION_END];
	assign session_valid_rise_enable =
		rise_edge_event_enable[OPER_BIT_SESSION_VALID];
	assign bus_power_good_rise_enable =
		rise_edge_event_enable[OPER_BIT_BUS_POWER_GOOD];
	assign downstream_detach_rise_enable =
		rise_edge_event_enable[OPER_BIT_DOWNSTREAM_DET];
	assign id_ground_fall_enable =
		fall_edge_event_enable[OPER_BIT_ID_GROUND];
	assign session_end_fall_enable =
		fall_edge_event_enable[OPER_BIT_SESSION_END];
	assign session_valid_fall_enable =
		fall_edge_event_enable[OPER_BIT_SESSION_VALID];
	assign bus_power_good_fall_enable =
		fall_edge_event_enable[OPER_BIT_BUS_POWER_GOOD];
	assign downstream_detach_fall_enable =
		fall_edge_event_enable[OPER_BIT_DOWNSTREAM_DET];
	assign id_ground_event_latched =
		detector_event_latch[OPER_BIT_ID_GROUND];
	assign session_end_event_latched =
		detector_event_latch[OPER_BIT_SESSION_END];
	assign session_valid_event_latched =
		detector_event_latch[OPER_BIT_SESSION_VALID];
	assign bus_power_good_event_latched =
		detector_event_latch[OPER_BIT_BUS_POWER_GOOD];
	assign downstream_detach_event_latched =
		detector_event_latch[OPER_BIT_DOWNSTREAM_DET];

	// masks follow the enables of each edge direction
	assign rise_mask = pack_src(id_ground_rise_enable,
	                            session_end_rise_enable,
	                            session_valid_rise_enable,
	                            bus_power_good_rise_enable,
	                            downstream_detach_rise_enable);
	assign fall_mask = pack_src(id_ground_fall_enable,
	                            session_end_fall_enable,
	                            session_valid_fall_enable,
	                            bus_power_good_fall_enable,
	                            downstream_detach_fall_enable);
	assign latch_view = pack_src(id_ground_event_latched,
	                             session_end_event_latched,
	                             session_valid_event_latched,
	                             bus_power_good_event_latched,
	                             downstream_detach_event_latched);

	// only enabled edge directions count as events
	assign events = (rise & rise_mask)
	              | (fall & fall_mask);

	// ------------------------------------------------------------
	// edge enable registers
	// ------------------------------------------------------------
	// one decode per register, shared by the write and read paths
	assign rise_op = op_of(REG_ADDR, OPER_ADDR_RISE_WR);
	assign fall_op = op_of(REG_ADDR, OPER_ADDR_FALL_WR);

	always_comb begin
		next_rise = rise_edge_event_enable;
		next_fall = fall_edge_event_enable;
		if (REG_WR) begin
			next_rise = apply_op(rise_op,
			                     rise_edge_event_enable,
			                     REG_WDATA);
			next_fall = apply_op(fall_op,
			                     fall_edge_event_enable,
			                     REG_WDATA);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			rise_edge_event_enable <= OPER_ENABLE_RESET;
		end else begin
			rise_edge_event_enable <= next_rise;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			fall_edge_event_enable <= OPER_ENABLE_RESET;
		end else begin
			fall_edge_event_enable <= next_fall;
		end
	end

	// ------------------------------------------------------------
	// event latch
	// ------------------------------------------------------------
	assign latch_read = REG_RD && (REG_ADDR == OPER_ADDR_LATCH);

	// a new event in the clearing cycle survives the clear, so
	// nothing is lost; low-power entry also clears
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			detector_event_latch <= OPER_LATCH_RESET;
		end else if (latch_read || LOW_POWER_ENTRY) begin
			detector_event_latch <= {3'h0, events};
		end else begin
			detector_event_latch <= detector_event_latch
			                      | {3'h0, events};
		end
	end

	// ------------------------------------------------------------
	// event request toward the link
	// ------------------------------------------------------------
	// RXCMD carries the levels after the change, so the link need
	// not poll the latch while its clock runs
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			EVENT_REQ <= 1'b0;
		end else begin
			EVENT_REQ <= |events;
		end
	end

	// status rides with the request, sampled every cycle
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			EVENT_STATUS <= 8'h00;
		end else begin
			EVENT_STATUS <= detector_live_status;
		end
	end

	assign INTR = |latch_view;

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		next_hit   = 1'b1;
		if (rise_op != OPER_OP_NONE) begin
			next_rdata = rise_edge_event_enable;
		end else if (fall_op != OPER_OP_NONE) begin
			next_rdata = fall_edge_event_enable;
		end else if (REG_ADDR == OPER_ADDR_STATUS) begin
			next_rdata = detector_live_status;
		end else if (REG_ADDR == OPER_ADDR_LATCH) begin
			next_rdata = {3'h0, latch_view};
		end else begin
			next_hit = 1'b0;
		end
	end

	// read data registered; sampled with the read strobe
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			REG_RDATA <= 8'h00;
			REG_HIT   <= 1'b0;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
			REG_HIT   <= next_hit;
		end
	end
endmodule : oper_event_logic

// File: oper_event_props.sv
// oper_event_props: port-level checks of the detector event logic
// assumes: bound into oper_event_logic; one clock, synchronous reset
`timescale 1ns/1ps
module oper_event_props
	import oper_pkg::*;
(
	input wire logic       MCLK,
	input wire logic       RSTN,
	input wire logic       ID_GROUND_LEVEL,
	input wire logic       SESSION_END_LEVEL,
	input wire logic       SESSION_VALID_LEVEL,
	input wire logic       BUS_POWER_GOOD_LEVEL,
	input wire logic       DOWNSTREAM_DETACH_LEVEL,
	input wire logic       LOW_POWER_ENTRY,
	input wire logic [5:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       REG_HIT,
	input wire logic       EVENT_REQ,
	input wire logic [7:0] EVENT_STATUS,
	input wire logic       INTR
);
	logic [7:0] lv;
	assign lv = {3'h0, ID_GROUND_LEVEL, SESSION_END_LEVEL,
		SESSION_VALID_LEVEL, BUS_POWER_GOOD_LEVEL, DOWNSTREAM_DETACH_LEVEL};
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// previous level is only real one cycle past reset
	sequence quiet;
		$past(RSTN) && $stable(lv);
	endsequence
	sequence rd_at(logic [5:0] a);
		REG_RD && REG_ADDR == a;
	endsequence
	status_read_a: assert property (
		rd_at(OPER_ADDR_STATUS) |=> REG_RDATA == $past(lv))
		else $error("status read differs from levels");
	status_live_a: assert property (
		$past(RSTN) |-> EVENT_STATUS == $past(lv))
		else $error("event status not live");
	map_hit_a: assert property (
		REG_RD |=> REG_HIT == ($past(REG_ADDR) inside {[6'h0D:6'h14]}))
		else $error("hit flag wrong");
	latch_read_a: assert property (rd_at(OPER_ADDR_LATCH) |=>
		REG_RDATA[7:5] == 3'h0 && (|REG_RDATA[4:0]) == $past(INTR))
		else $error("latch read wrong");
	quiet_noreq_a: assert property (quiet |=> !EVENT_REQ)
		else $error("event without level change");
	read_clear_a: assert property (
		rd_at(OPER_ADDR_LATCH) ##0 quiet |=> !INTR)
		else $error("latch not cleared by read");
	lp_clear_a: assert property (LOW_POWER_ENTRY ##0 quiet |=> !INTR)
		else $error("latch not cleared on low power");
	intr_hold_a: assert property (INTR && !LOW_POWER_ENTRY &&
		!(REG_RD && REG_ADDR == OPER_ADDR_LATCH) |=> INTR)
		else $error("latch lost");
	req_intr_a: assert property (EVENT_REQ |-> INTR)
		else $error("event not latched");
endmodule : oper_event_props
bind oper_event_logic oper_event_props u_props (.MCLK(MCLK), .RSTN(RSTN),
	.ID_GROUND_LEVEL(ID_GROUND_LEVEL), .SESSION_END_LEVEL(SESSION_END_LEVEL),
	.SESSION_VALID_LEVEL(SESSION_VALID_LEVEL),
	.BUS_POWER_GOOD_LEVEL(BUS_POWER_GOOD_LEVEL),
	.DOWNSTREAM_DETACH_LEVEL(DOWNSTREAM_DETACH_LEVEL),
	.LOW_POWER_ENTRY(LOW_POWER_ENTRY), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_HIT(REG_HIT), .EVENT_REQ(EVENT_REQ), .EVENT_STATUS(EVENT_STATUS),
	.INTR(INTR));

// File: oper_link_model.sv
// oper_link_model: link side, counts RXCMD requests
// assumes: EVENT_REQ is one pulse per RXCMD
`timescale 1ns/1ps
module oper_link_model (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic event_req,
	output int        n_rxcmd
);
	// never reads the latch: clock runs, RXCMDs carry every enabled change
	always_ff @(posedge mclk) begin
		if (!rstn) n_rxcmd <= 0;
		else if (event_req) n_rxcmd <= n_rxcmd + 1;
	end
endmodule : oper_link_model

// File: otg_phy_event_interrupt_logic_tb.sv
// otg_phy_event_interrupt_logic_tb: random register and detector traffic
// assumes: checker bound into the design, link model beside it
`timescale 1ns/1ps
module otg_phy_event_interrupt_logic_tb
	import oper_pkg::*;
;
	logic mclk, rstn, lp, wr, rd, req, hit, intr;
	logic [4:0] lv, ev, lat;
	logic [5:0] addr;
	logic [7:0] wd, rdata, est, re, fe;
	logic [31:0] seed;
	int n_mismatch, n_checks, n_rx, exp_rx;
	oper_event_logic DUT (.MCLK(mclk), .RSTN(rstn), .ID_GROUND_LEVEL(lv[4]),
		.SESSION_END_LEVEL(lv[3]), .SESSION_VALID_LEVEL(lv[2]),
		.BUS_POWER_GOOD_LEVEL(lv[1]), .DOWNSTREAM_DETACH_LEVEL(lv[0]),
		.LOW_POWER_ENTRY(lp), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wd), .REG_RDATA(rdata), .REG_HIT(hit), .EVENT_REQ(req),
		.EVENT_STATUS(est), .INTR(intr));
	oper_link_model u_link (.mclk(mclk), .rstn(rstn), .event_req(req),
		.n_rxcmd(n_rx));
	function automatic logic [31:0] step(logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction : step
	// reserved enable bits never stick
	function automatic logic [7:0] upd(logic [7:0] c, d, logic [5:0] k);
		return (k == 6'h00 ? d : k == 6'h01 ? c | d : c & ~d) & 8'h1F;
	endfunction : upd
	function automatic logic [7:0] exp_rd(logic [5:0] x);
		if (x - 6'h0D < 6'h03) return re;
		if (x - 6'h0D < 6'h06) return fe;
		if (x == OPER_ADDR_STATUS) return {3'h0, lv};
		if (x == OPER_ADDR_LATCH) return {3'h0, lat};
		return 8'h00;
	endfunction : exp_rd
	task automatic chk(logic [7:0] got, logic [7:0] want);
		n_checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic chk_flag(logic got, logic want);
		n_checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: flag %b want %b", $time, got, want);
		end
	endtask : chk_flag
	task automatic chk_count(logic [31:0] got, logic [31:0] want);
		n_checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: count %0d want %0d",
				$time, got, want);
		end
	endtask : chk_count
	task automatic wr_reg(logic [5:0] x, logic [7:0] d);
		if (x - 6'h0D < 6'h03) re = upd(re, d, x - 6'h0D);
		else if (x - 6'h0D < 6'h06) fe = upd(fe, d, x - 6'h10);
		{wr, addr, wd} = {1'b1, x, d};
		@(negedge mclk);
		wr = 0;
		@(negedge mclk);
	endtask : wr_reg
	task automatic rd_reg(logic [5:0] x);
		logic [7:0] e;
		e = exp_rd(x);
		{rd, addr} = {1'b1, x};
		@(negedge mclk);
		rd = 0;
		chk(rdata, e);
		chk_flag(hit, x >= 6'h0D && x <= 6'h14);
		if (x == OPER_ADDR_LATCH) lat = 0;
		@(negedge mclk);
	endtask : rd_reg
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	// run needs about 570 cycles; allow far more
	initial begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		{rstn, lp, wr, rd, lv, addr, wd, lat} = '0;
		{n_mismatch, n_checks, exp_rx} = '0;
		re = OPER_ENABLE_RESET;
		fe = OPER_ENABLE_RESET;
		seed = 32'h000140EE;
		repeat (8) @(negedge mclk);
		rstn = 1;
		for (int i = 0; i < 9; i++) rd_reg(6'h0D + 6'(i));
		repeat (24) begin
			seed = step(seed);
			wr_reg(6'h0D + {3'h0, seed[2:0]}, seed[15:8]);
			rd_reg(6'h0D + {3'h0, seed[18:16]});
		end
		repeat (30) begin
			seed = step(seed);
			wr_reg(OPER_ADDR_RISE_WR, seed[7:0]);
			wr_reg(OPER_ADDR_FALL_WR, seed[15:8]);
			repeat (6) begin
				seed = step(seed);
				ev = (~lv & seed[4:0] & re[4:0]) | (lv & ~seed[4:0] & fe[4:0]);
				lv = seed[4:0];
				@(negedge mclk);
				chk_flag(req, |ev);
				chk(est, {3'h0, lv});
				lat = lat | ev;
				exp_rx += int'(|ev);
			end
			chk_flag(intr, |lat);
			if (seed[8]) begin
				lp = 1;
				@(negedge mclk);
				lp = 0;
				lat = 0;
			end
			rd_reg(seed[9] ? OPER_ADDR_STATUS : OPER_ADDR_LATCH);
			rd_reg(OPER_ADDR_LATCH);
		end
		// event in the reading cycle outlives the clear
		wr_reg(OPER_ADDR_RISE_SET, 8'h1F);
		wr_reg(OPER_ADDR_FALL_SET, 8'h1F);
		lv[0] = ~lv[0];
		rd_reg(OPER_ADDR_LATCH);
		exp_rx++;
		chk_flag(intr, 1'b1);
		chk_count(n_rx, exp_rx);
		// mid-run reset with levels low, so no false edge follows
		{rstn, lv} = '0;
		repeat (2) @(negedge mclk);
		rstn = 1;
		{re, fe, lat} = {OPER_ENABLE_RESET, OPER_ENABLE_RESET, 5'h00};
		rd_reg(OPER_ADDR_RISE_WR);
		rd_reg(OPER_ADDR_FALL_CLR);
		rd_reg(OPER_ADDR_LATCH);
		print_verdict();
	end
endmodule : otg_phy_event_interrupt_logic_tb
